// File: panel_display_menu.sv
// front-panel menu controller: buttons in, five seven-segment digits out
// assumes clean synchronous buttons, and that the item value arrives as five bcd digits
`timescale 1ns/1ps
`default_nettype none
`include "panel_consts.svh"

module panel_display_menu
	import panel_pkg::*;
#(
	parameter int BOOT_TICKS = `BOOT_TIME_MS * `CLK_KHZ
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire btn_t buttons,
	input wire logic point_table_method,
	input wire logic program_method,
	input wire logic [3:0] initial_status_item_param,
	input wire logic axis_name_valid,
	input wire char_t [`DIGITS-1:0] axis_name,
	input wire logic [4*`DIGITS-1:0] status_bcd,
	output logic [3:0] status_item,
	output mode_t menu_mode,
	output seg_t [`DIGITS-1:0] segments
);

	localparam menu_state_t STATE_RST = '{
		mode: MD_STATUS, boot: B_INIT, item: `ITEM_RST, show_data: `SHOW_RST,
		sub: `SUB_RST, timer: '0, chars: {`DIGITS{CH_BLANK}},
		segs: {`DIGITS{7'h00}}
	};
	localparam logic [`TIMER_W-1:0] BOOT_LAST = `TIMER_W'(BOOT_TICKS - 1);

	menu_state_t s_q;
	menu_state_t s_d;
	btn_t press;
	logic pos_method;
	seg_t [`DIGITS-1:0] seg_w;

	press_detect u_press (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.btn_level(buttons),
		.btn_press(press)
	);

	assign pos_method = point_table_method | program_method;
	assign status_item = s_q.item;
	assign menu_mode = s_q.mode;
	assign segments = s_q.segs;

	function automatic seg_t seg_of(input char_t c);
		case (c)
			CH_0: seg_of = 7'h3F;
			CH_1: seg_of = 7'h06;
			CH_2: seg_of = 7'h5B;
			CH_3: seg_of = 7'h4F;
			CH_4: seg_of = 7'h66;
			CH_5, CH_S: seg_of = 7'h6D;
			CH_6: seg_of = 7'h7D;
			CH_7: seg_of = 7'h07;
			CH_8: seg_of = 7'h7F;
			CH_9: seg_of = 7'h6F;
			CH_A: seg_of = 7'h77;
			CH_B: seg_of = 7'h7C;
			CH_C: seg_of = 7'h39;
			CH_D: seg_of = 7'h5E;
			CH_E: seg_of = 7'h79;
			CH_F: seg_of = 7'h71;
			CH_H: seg_of = 7'h76;
			CH_J: seg_of = 7'h1E;
			CH_L: seg_of = 7'h38;
			CH_N: seg_of = 7'h54;
			CH_O: seg_of = 7'h5C;
			CH_P: seg_of = 7'h73;
			CH_R: seg_of = 7'h50;
			CH_T: seg_of = 7'h78;
			CH_U: seg_of = 7'h3E;
			CH_DASH: seg_of = 7'h40;
			default: seg_of = 7'h00;
		endcase
	endfunction

	// symbols of the status items in selection order
	function automatic char_t item_symbol(input logic [3:0] idx);
		case (idx)
			4'h0: item_symbol = CH_C;
			4'h1: item_symbol = CH_R;
			4'h2: item_symbol = CH_E;
			4'h3: item_symbol = CH_P;
			4'h4: item_symbol = CH_N;
			4'h5: item_symbol = CH_F;
			4'h6: item_symbol = CH_U;
			4'h7: item_symbol = CH_L;
			4'h8: item_symbol = CH_J;
			4'h9: item_symbol = CH_B;
			default: item_symbol = CH_T;
		endcase
	endfunction

	function automatic char_t group_letter(input mode_t m);
		case (m)
			MD_BASIC: group_letter = CH_A;
			MD_GAIN: group_letter = CH_B;
			MD_EXT: group_letter = CH_C;
			MD_IO: group_letter = CH_D;
			MD_EXT2: group_letter = CH_E;
			MD_EXT3: group_letter = CH_F;
			default: group_letter = CH_T;
		endcase
	endfunction

	function automatic logic [3:0] step(input logic [3:0] v, input logic [3:0] n,
		input logic fwd);
		if (fwd) begin
			step = (v == n - 4'h1) ? 4'h0 : v + 4'h1;
		end else begin
			step = (v == 4'h0) ? n - 4'h1 : v - 4'h1;
		end
	endfunction

	// --------------------------------------------------------------
	// character to segment encoding, one encoder per digit
	// --------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `DIGITS; g++) begin : g_digit
			assign seg_w[g] = seg_of(s_q.chars[g]);
		end
	endgenerate

	// --------------------------------------------------------------
	// menu state
	// --------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.segs = seg_w;
		case (s_q.boot)
			B_INIT: begin
				// parameter caught after reset release, never under reset
				s_d.item = (initial_status_item_param < `STATUS_ITEMS) ?
					initial_status_item_param : `ITEM_RST;
				s_d.timer = '0;
				s_d.show_data = 1'b0;
				if (axis_name_valid) begin
					s_d.boot = B_AXIS;
				end else if (pos_method) begin
					s_d.boot = B_POS;
				end else begin
					s_d.boot = B_SYM;
				end
			end
			B_AXIS, B_POS, B_SYM: begin
				if (s_q.timer == BOOT_LAST) begin
					s_d.timer = '0;
					case (s_q.boot)
						B_AXIS: s_d.boot = pos_method ? B_POS : B_SYM;
						B_POS: s_d.boot = B_SYM;
						default: begin
							s_d.boot = B_RUN;
							s_d.show_data = 1'b1;
						end
					endcase
				end else begin
					s_d.timer = s_q.timer + `TIMER_W'(1);
				end
			end
			default: begin
				if (press.mode) begin
					s_d.sub = `SUB_RST;
					s_d.show_data = 1'b0;
					if (s_q.mode == MD_POSCTL) begin
						s_d.mode = MD_STATUS;
					end else if (s_q.mode == MD_ALARM && !point_table_method) begin
						s_d.mode = MD_BASIC;
					end else begin
						s_d.mode = mode_t'(s_q.mode + 4'h1);
					end
				end else if (press.up || press.down) begin
					if (s_q.mode == MD_STATUS) begin
						s_d.item = step(s_q.item, `STATUS_ITEMS, press.up);
						s_d.show_data = 1'b0;
					end else if (s_q.mode == MD_DIAG) begin
						s_d.sub = step(s_q.sub, `DIAG_SCREENS, press.up);
					end else if (s_q.mode == MD_ALARM) begin
						s_d.sub = step(s_q.sub, `ALARM_SCREENS, press.up);
					end
				end else if (press.set && s_q.mode == MD_STATUS) begin
					s_d.show_data = 1'b1;
				end
			end
		endcase

		// text for the next display refresh, always five characters
		case (s_q.boot)
			B_INIT: s_d.chars = {`DIGITS{CH_BLANK}};
			B_AXIS: s_d.chars = axis_name;
			B_POS: s_d.chars = {CH_BLANK, CH_BLANK, CH_P, CH_O, CH_S};
			default: begin
				case (s_q.mode)
					MD_STATUS: begin
						if (s_q.show_data) begin
							for (int k = 0; k < `DIGITS; k++) begin
								s_d.chars[k] = char_t'({2'b00, status_bcd[4*k +: 4]});
							end
						end else begin
							s_d.chars = {item_symbol(s_q.item), CH_BLANK, CH_BLANK,
								CH_BLANK, CH_BLANK};
						end
					end
					MD_TUNE: s_d.chars = {CH_T, CH_U, CH_N, CH_E, CH_BLANK};
					MD_DIAG: s_d.chars = {CH_D, CH_DASH, CH_BLANK, CH_BLANK,
						char_t'({2'b00, s_q.sub + 4'h1})};
					MD_ALARM: s_d.chars = {CH_A, CH_L, CH_DASH, CH_BLANK,
						char_t'({2'b00, s_q.sub + 4'h1})};
					MD_PTABLE: s_d.chars = {CH_P, CH_T, CH_0, CH_0, CH_1};
					default: s_d.chars = {CH_P, group_letter(s_q.mode), CH_BLANK,
						CH_0, CH_1};
				endcase
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_mode_advance: assert property (
		s_q.boot == B_RUN && press.mode && s_q.mode == MD_STATUS |=> s_q.mode == MD_TUNE
	) else $error("mode press did not advance status to tuning");

	a_mode_wrap: assert property (
		s_q.boot == B_RUN && press.mode && s_q.mode == MD_POSCTL |=> s_q.mode == MD_STATUS
	) else $error("mode press in last mode did not wrap");

	a_ptable_skip: assert property (
		s_q.boot == B_RUN && press.mode && s_q.mode == MD_ALARM && !point_table_method
		|=> s_q.mode == MD_BASIC
	) else $error("point table mode not skipped");

	a_ptable_enter: assert property (
		s_q.boot == B_RUN && press.mode && s_q.mode == MD_ALARM && point_table_method
		|=> s_q.mode == MD_PTABLE
	) else $error("point table mode not entered");

	a_boot_status: assert property (
		s_q.boot != B_RUN |-> s_q.mode == MD_STATUS
	) else $error("power-on display left status mode");

	a_pos_text: assert property (
		s_q.boot == B_POS ##1 s_q.boot == B_POS
		|-> s_q.chars == {CH_BLANK, CH_BLANK, CH_P, CH_O, CH_S}
	) else $error("positioning text not shown");

	a_sym_hold: assert property (
		s_q.boot == B_SYM && s_q.timer != BOOT_LAST |=> s_q.boot == B_SYM && !s_q.show_data
	) else $error("power-on symbol left early");

	a_sym_done: assert property (
		s_q.boot == B_SYM && s_q.timer == BOOT_LAST |=> s_q.boot == B_RUN && s_q.show_data
	) else $error("power-on symbol did not switch to data");

	a_axis_first: assert property (
		s_q.boot == B_INIT && axis_name_valid |=> s_q.boot == B_AXIS ##1 s_q.chars == $past(axis_name)
	) else $error("axis name not shown first");

	a_item_up: assert property (
		s_q.boot == B_RUN && s_q.mode == MD_STATUS && press.up && !press.mode
		|=> !s_q.show_data && s_q.item == (($past(s_q.item) == `STATUS_ITEMS - 4'h1) ?
			4'h0 : $past(s_q.item) + 4'h1)
	) else $error("up press did not step the status item");

	a_set_data: assert property (
		s_q.boot == B_RUN && s_q.mode == MD_STATUS && press.set && !press.mode
		&& !press.up && !press.down |=> s_q.show_data
	) else $error("set press did not select data view");

	c_wrap: cover property (s_q.boot == B_RUN && press.mode && s_q.mode == MD_POSCTL);
	c_ptable: cover property (s_q.mode == MD_PTABLE);
	c_boot_done: cover property (s_q.boot == B_SYM ##1 s_q.boot == B_RUN);
	c_axis: cover property (s_q.boot == B_AXIS ##1 s_q.boot == B_POS);

endmodule
`default_nettype wire

// File: panel_consts.svh
// named constants for the front-panel menu controller
// assumes a 25 MHz ref_clk; included by the package and both modules
`ifndef PANEL_CONSTS_SVH
`define PANEL_CONSTS_SVH

`define CLK_KHZ 25000
`define BOOT_TIME_MS 2000
`define TIMER_W 26
`define DIGITS 5
`define BTN_W 4
`define STATUS_ITEMS 4'hB
`define DIAG_SCREENS 4'h9
`define ALARM_SCREENS 4'h3
`define ITEM_RST 4'h0
`define SUB_RST 4'h0
`define SHOW_RST 1'b0

`endif

// File: panel_pkg.sv
// types shared by the front-panel menu controller and its button detector
// assumes panel_consts.svh is on the include path
`include "panel_consts.svh"

package panel_pkg;

	// digits occupy codes 0 to 9 so a bcd digit casts straight to a character
	typedef enum logic [5:0] {
		CH_0, CH_1, CH_2, CH_3, CH_4, CH_5, CH_6, CH_7, CH_8, CH_9,
		CH_A, CH_B, CH_C, CH_D, CH_E, CH_F, CH_H, CH_J, CH_L, CH_N,
		CH_O, CH_P, CH_R, CH_S, CH_T, CH_U, CH_DASH, CH_BLANK
	} char_t;

	typedef enum logic [3:0] {
		MD_STATUS, MD_TUNE, MD_DIAG, MD_ALARM, MD_PTABLE, MD_BASIC,
		MD_GAIN, MD_EXT, MD_IO, MD_EXT2, MD_EXT3, MD_POSCTL
	} mode_t;

	typedef enum logic [2:0] {
		B_INIT, B_AXIS, B_POS, B_SYM, B_RUN
	} boot_t;

	// segment order is g f e d c b a, high lights the segment
	typedef logic [6:0] seg_t;

	typedef struct packed {
		logic mode;
		logic up;
		logic down;
		logic set;
	} btn_t;

	typedef struct packed {
		mode_t mode;
		boot_t boot;
		logic [3:0] item;
		logic show_data;
		logic [3:0] sub;
		logic [`TIMER_W-1:0] timer;
		char_t [`DIGITS-1:0] chars;
		seg_t [`DIGITS-1:0] segs;
	} menu_state_t;

endpackage

// File: press_detect.sv
// rising-edge detector for the four panel buttons
// assumes button levels are already clean and synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "panel_consts.svh"

module press_detect
	import panel_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire btn_t btn_level,
	output var btn_t btn_press
);

	logic [`BTN_W-1:0] prev_q;
	logic [`BTN_W-1:0] prev_d;
	logic [`BTN_W-1:0] lvl;
	logic [`BTN_W-1:0] edge_w;

	assign lvl = btn_level;

	// --------------------------------------------------------------
	// one pulse per press
	// --------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `BTN_W; i++) begin : g_btn
			assign edge_w[i] = lvl[i] & ~prev_q[i];
		end
	endgenerate

	assign btn_press = edge_w;

	always_comb begin
		prev_d = lvl;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= '1;
		end else begin
			prev_q <= prev_d;
		end
	end

endmodule
`default_nettype wire

// File: panel_operator.sv
// operator model: presses one button pattern at a time on the front panel
// assumes press() is called from a process that sits just after a ref_clk edge
`timescale 1ns/1ps
`default_nettype none

module panel_operator
	import panel_pkg::*;
(
	input wire logic ref_clk,
	output var btn_t buttons
);
	// ----------------
	// press sequencing
	// ----------------
	initial buttons = '0;

	// a level held for hold cycles, then low long enough for the next press to count
	task automatic press(input btn_t b, input int hold);
		@(posedge ref_clk);
		#1 buttons = b;
		repeat (hold) @(posedge ref_clk);
		#1 buttons = '0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
endmodule

`default_nettype wire

// File: panel_display_menu_bench.sv
// self-checking bench for the front-panel menu controller
// assumes the operator model owns the buttons; boot phases shortened to BT cycles
`timescale 1ns/1ps
`default_nettype none

module panel_display_menu_bench;
	import panel_pkg::*;
	localparam int BT = 8;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	btn_t buttons;
	logic point_table_method = 1'b1;
	logic program_method = 1'b0;
	logic [3:0] initial_status_item_param = 4'h0;
	logic axis_name_valid = 1'b1;
	char_t [4:0] axis_name = {CH_A, CH_H, CH_0, CH_1, CH_BLANK};
	logic [19:0] status_bcd = 20'h00000;
	logic [3:0] status_item;
	mode_t menu_mode;
	seg_t [4:0] segments;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [15:0] lfsr = 16'hF7AA;

	panel_display_menu #(.BOOT_TICKS(BT)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.buttons(buttons), .point_table_method(point_table_method),
		.program_method(program_method), .initial_status_item_param(initial_status_item_param),
		.axis_name_valid(axis_name_valid), .axis_name(axis_name), .status_bcd(status_bcd),
		.status_item(status_item), .menu_mode(menu_mode), .segments(segments));
	panel_operator i_op (.ref_clk(ref_clk), .buttons(buttons));

	always #20 ref_clk = ~ref_clk;

	// ------------------
	// helpers and checks
	// ------------------
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ceiling well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("unexpected at %0t: run did not finish", $time);
			stop_test();
		end
	end

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	function automatic seg_t seg_dig(input logic [3:0] d);
		case (d)
			4'h0: return 7'h3F;
			4'h1: return 7'h06;
			4'h2: return 7'h5B;
			4'h3: return 7'h4F;
			4'h4: return 7'h66;
			4'h5: return 7'h6D;
			4'h6: return 7'h7D;
			4'h7: return 7'h07;
			4'h8: return 7'h7F;
			default: return 7'h6F;
		endcase
	endfunction

	// segments of each status item's symbol, in selection order
	function automatic seg_t sym_seg(input int i);
		case (i)
			0: return 7'h39;
			1: return 7'h50;
			2: return 7'h79;
			3: return 7'h73;
			4: return 7'h54;
			5: return 7'h71;
			6: return 7'h3E;
			7: return 7'h38;
			8: return 7'h1E;
			9: return 7'h7C;
			default: return 7'h78;
		endcase
	endfunction

	// leftmost character on entry to a mode: symbol, t, d, A or P
	function automatic seg_t lead_seg(input mode_t m, input int i);
		case (m)
			MD_STATUS: return sym_seg(i);
			MD_TUNE: return 7'h78;
			MD_DIAG: return 7'h5E;
			MD_ALARM: return 7'h77;
			default: return 7'h73;
		endcase
	endfunction

	function automatic logic [34:0] data_segs();
		seg_t [4:0] r;
		for (int k = 0; k < 5; k++)
			r[k] = seg_dig(status_bcd[4*k+:4]);
		return r;
	endfunction

	function automatic mode_t next_mode(input mode_t m, input logic pt);
		if (m == MD_POSCTL)
			return MD_STATUS;
		if (m == MD_ALARM && !pt)
			return MD_BASIC;
		return mode_t'(m + 4'h1);
	endfunction

	task automatic check(input logic [34:0] seen, input logic [34:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// reset, then count cycles until the chosen item's data shows
	task automatic boot(input logic ax, input logic pt, input logic pg, output int t);
		reset_n = 1'b0;
		axis_name_valid = ax;
		point_table_method = pt;
		program_method = pg;
		// program method boot also tries an out-of-range item, which falls back to item 0
		initial_status_item_param = pg ? 4'hF : 4'(rnd() % 11);
		for (int k = 0; k < 5; k++)
			status_bcd[4*k+:4] = 4'(rnd() % 10);
		repeat (3) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		fork
			i_op.press(btn_t'(4'h8), 1);
		join_none
		t = 0;
		while (segments !== data_segs() && t < 300) begin
			@(posedge ref_clk);
			#1 t++;
		end
		check(status_item, (initial_status_item_param < 4'hB) ? initial_status_item_param : 4'h0,
			"boot item");
		check(segments, data_segs(), "boot data");
		check(menu_mode, MD_STATUS, "boot mode");
		$display("test boot done");
	endtask

	// step sub screens with up and down; the rightmost digit is the screen number
	task automatic subs(input int n);
		int sub;
		logic [15:0] r;
		sub = 1;
		check(segments[0], seg_dig(4'(sub)), "first screen");
		repeat (8) begin
			r = rnd();
			i_op.press(btn_t'(r[0] ? 4'h4 : 4'h2), r[3] ? 4 : 1);
			sub = r[0] ? (sub == n ? 1 : sub + 1) : (sub == 1 ? n : sub - 1);
			check(segments[0], seg_dig(4'(sub)), "screen number");
		end
	endtask

	// -----------
	// main thread
	// -----------
	initial begin
		int t1, t2, t3, item;
		logic [15:0] r;
		mode_t m;
		boot(1'b1, 1'b1, 1'b0, t1);
		item = initial_status_item_param;
		repeat (12) begin
			r = rnd();
			i_op.press(btn_t'(r[0] ? 4'h4 : 4'h2), r[3] ? 4 : 1);
			item = r[0] ? (item == 10 ? 0 : item + 1) : (item == 0 ? 10 : item - 1);
			check(status_item, item, "item step");
			check(segments[3:0], 28'h0, "symbol width");
			check(segments[4], sym_seg(item), "item symbol");
			status_bcd[4*r[6:5]+:4] = 4'(r[15:8] % 10);
			i_op.press(btn_t'(4'h1), 1);
			check(segments, data_segs(), "item data");
		end
		$display("test status items done");
		i_op.press(btn_t'(4'h8), 1);
		i_op.press(btn_t'(4'h8), 1);
		check(menu_mode, MD_DIAG, "to diagnosis");
		subs(9);
		i_op.press(btn_t'(4'h8), 3);
		check(menu_mode, MD_ALARM, "to alarm");
		subs(3);
		$display("test sub screens done");
		for (int pt = 1; pt >= 0; pt--) begin
			point_table_method = pt[0];
			m = menu_mode;
			do begin
				m = next_mode(m, pt[0]);
				i_op.press(btn_t'(4'h8), 1);
				check(menu_mode, m, "mode ring");
				check(segments[4], lead_seg(m, item), "mode text");
			end while (m != MD_STATUS);
			check(segments[3:0], 28'h0, "symbol after wrap");
		end
		$display("test mode ring done");
		boot(1'b0, 1'b0, 1'b0, t2);
		boot(1'b0, 1'b0, 1'b1, t3);
		check(t1 - t2, 2 * BT, "axis and pos phases");
		check(t3 - t2, BT, "pos phase");
		$display("test boot timing done");
		stop_test();
	end
endmodule

`default_nettype wire
